// ===== design/scrs_params.svh
// timing counts, register offsets, field positions and reset values
// assumes the block clock runs at SCRS_CLK_MHZ; counts derive from it
`ifndef SCRS_PARAMS_SVH
`define SCRS_PARAMS_SVH

`define SCRS_CLK_MHZ 200
`define SCRS_MIN_LOW_MS 2
`define SCRS_RUNUP_S 2
`define SCRS_OPER_MAX_S 20
`define SCRS_RAMP_MS 10
`define SCRS_BLINK_MS 250
`define SCRS_MIN_LOW_CYC (`SCRS_MIN_LOW_MS * `SCRS_CLK_MHZ * 1000)
`define SCRS_RUNUP_CYC (`SCRS_RUNUP_S * `SCRS_CLK_MHZ * 1000000)
`define SCRS_RAMP_CYC (`SCRS_RAMP_MS * `SCRS_CLK_MHZ * 1000)
`define SCRS_BLINK_CYC (`SCRS_BLINK_MS * `SCRS_CLK_MHZ * 1000)

`define SCRS_CTRL_OFS 8'h00
`define SCRS_CFG_DATA_OFS 8'h04
`define SCRS_STATUS_OFS 8'h08
`define SCRS_IRQ_STAT_OFS 8'h0C
`define SCRS_IRQ_CLR_OFS 8'h10
`define SCRS_IRQ_EN_OFS 8'h14

`define SCRS_CTRL_CFG_START 0
`define SCRS_CTRL_CLR_FAULT 1
`define SCRS_CTRL_OUT_LSB 8
`define SCRS_CFG_LAST 2'h2
`define SCRS_WIRE_W 8

`define SCRS_EV_RUN 0
`define SCRS_EV_STOP 1
`define SCRS_EV_CFG_ERR 2
`define SCRS_EV_TEST_ERR 3

`define SCRS_IRQ_EN_RST 4'h0
`define SCRS_OUTS_RST 4'h0
`define SCRS_ORDER_NUM 32'h0000_0A5A
`define SCRS_SERIAL_NUM 32'h0000_1234

`endif

// ===== design/scrs_pkg.sv
// types shared by the sequencer files
// assumes nothing beyond a SystemVerilog compiler
package scrs_pkg;
    typedef enum logic [2:0] {
        ST_PWR = 3'b000,
        ST_TORQ_OFF = 3'b001,
        ST_CONFIG = 3'b010,
        ST_STARTUP = 3'b011,
        ST_RUN = 3'b100,
        ST_STOP_RAMP = 3'b101
    } scrs_state_e;
    typedef logic [31:0] scrs_word_t;
endpackage : scrs_pkg

// ===== design/scrs_timer.sv
// cycle counter: counts while run_in, flags the limit, may wrap
// assumes run_in is synchronous to clk_in
`timescale 1ns/1ps
module scrs_timer
    import scrs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic run_in,
    input wire logic wrap_in,
    input wire scrs_word_t limit_in,
    output logic done_out
);
    scrs_word_t cnt_q;
    scrs_word_t cnt_d;

    assign done_out = run_in && (cnt_q == limit_in);

    always_comb
    begin
        cnt_d = cnt_q;
        if (!run_in)
            cnt_d = 32'h0;
        else if (cnt_q == limit_in)
            cnt_d = wrap_in ? 32'h0 : cnt_q;
        else
            cnt_d = cnt_q + 32'h1;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            cnt_q <= 32'h0;
        else
            cnt_q <= cnt_d;
    end
endmodule : scrs_timer

// ===== design/scrs_top.sv
// startup and reset sequencer of a drive safety card, AHB-Lite slave
// assumes one clock, synchronous low reset, a single zero-wait slave
`timescale 1ns/1ps
`include "scrs_params.svh"
module scrs_top
    import scrs_pkg::*;
#(
    parameter int unsigned MIN_LOW_CYC = `SCRS_MIN_LOW_CYC,
    parameter int unsigned RUNUP_CYC = `SCRS_RUNUP_CYC,
    parameter int unsigned RAMP_CYC = `SCRS_RAMP_CYC,
    parameter int unsigned BLINK_CYC = `SCRS_BLINK_CYC,
    parameter logic [31:0] ORDER_NUM = `SCRS_ORDER_NUM,
    parameter logic [31:0] SERIAL_NUM = `SCRS_SERIAL_NUM
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic supply_ok_in,
    input wire logic stop_request_input_in,
    input wire logic redundant_reset_input_in,
    input wire logic [7:0] wiring_in,
    input wire logic selftest_ok_in,
    input wire logic pulse_disable_fb_in,
    input wire logic fault_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic ready_out,
    output logic [3:0] configurable_outputs_out,
    output logic power_enable_out,
    output logic controlled_stop_out,
    output logic torque_off_feedback_out,
    output logic pulse_test_out,
    output logic cfg_led_out,
    output logic run_led_out,
    output logic sto_led_out,
    output logic irq_out
);
    // ------------------------------------------------------------
    // input synchronisers and timers
    // ------------------------------------------------------------
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic both_high;
    logic low_done;
    logic su_done;
    logic ramp_done;
    logic blink_tick;
    scrs_state_e state_q;
    scrs_state_e state_d;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
        end
        else
        begin
            sync1_q <= {redundant_reset_input_in, stop_request_input_in};
            sync2_q <= sync1_q;
        end
    end

    assign both_high = &sync2_q;

    // the low must last MIN_LOW_CYC before it arms a reset
    scrs_timer u_low (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(!both_high),
        .wrap_in(1'b0), .limit_in(32'(MIN_LOW_CYC - 1)),
        .done_out(low_done)
    );
    scrs_timer u_su (
        .clk_in(clk_in), .rst_b_in(rst_b_in),
        .run_in(state_q == ST_STARTUP), .wrap_in(1'b0),
        .limit_in(32'(RUNUP_CYC - 1)), .done_out(su_done)
    );
    scrs_timer u_ramp (
        .clk_in(clk_in), .rst_b_in(rst_b_in),
        .run_in(state_q == ST_STOP_RAMP), .wrap_in(1'b0),
        .limit_in(32'(RAMP_CYC - 1)), .done_out(ramp_done)
    );
    scrs_timer u_blink (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .run_in(1'b1),
        .wrap_in(1'b1), .limit_in(32'(BLINK_CYC - 1)),
        .done_out(blink_tick)
    );

    // ------------------------------------------------------------
    // bus phase capture
    // ------------------------------------------------------------
    logic wr_q;
    logic wr_d;
    logic [7:0] waddr_q;
    logic [7:0] waddr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [3:0] outs_q;
    logic [3:0] outs_d;
    logic [3:0] irq_en_q;
    logic [3:0] irq_en_d;
    logic [3:0] irq_st_q;
    logic [3:0] irq_st_d;
    logic [3:0] ev;
    logic ctrl_wr;
    logic cfg_wr;
    logic addr_ok;

    assign addr_ok = hsel_in && hready_in && htrans_in[1];
    assign ctrl_wr = wr_q && (waddr_q == `SCRS_CTRL_OFS);
    assign cfg_wr = wr_q && (waddr_q == `SCRS_CFG_DATA_OFS);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    logic [1:0] cfg_cnt_q;
    logic [1:0] cfg_cnt_d;
    logic cfg_bad_q;
    logic cfg_bad_d;
    logic cfg_valid_q;
    logic cfg_valid_d;
    logic boot_q;
    logic boot_d;
    logic armed_q;
    logic armed_d;
    logic blink_q;
    logic blink_d;
    logic word_bad;
    logic cfg_end;
    logic clr_cmd;
    logic pwr_on;

    assign clr_cmd = ctrl_wr && hwdata_in[`SCRS_CTRL_CLR_FAULT];
    assign cfg_end = (state_q == ST_CONFIG) && cfg_wr &&
                     (cfg_cnt_q == `SCRS_CFG_LAST);

    always_comb
    begin
        // order number, serial number, then wiring plus feasibility
        word_bad = 1'b0;
        if (cfg_cnt_q == 2'h0)
            word_bad = hwdata_in != ORDER_NUM;
        else if (cfg_cnt_q == 2'h1)
            word_bad = hwdata_in != SERIAL_NUM;
        else
            word_bad = (hwdata_in[7:0] != wiring_in) ||
                       (hwdata_in[31:16] != 16'h0);
    end

    always_comb
    begin
        state_d = state_q;
        cfg_cnt_d = cfg_cnt_q;
        cfg_bad_d = cfg_bad_q;
        cfg_valid_d = cfg_valid_q;
        boot_d = boot_q;
        armed_d = armed_q || low_done;
        blink_d = blink_tick ? !blink_q : blink_q;
        ev = 4'h0;
        case (state_q)
            ST_PWR:
                if (supply_ok_in)
                    state_d = ST_TORQ_OFF;
            ST_TORQ_OFF:
                if (ctrl_wr && hwdata_in[`SCRS_CTRL_CFG_START])
                begin
                    state_d = ST_CONFIG;
                    cfg_cnt_d = 2'h0;
                    cfg_bad_d = 1'b0;
                end
                else if (both_high &&
                         (armed_q || clr_cmd || (boot_q && cfg_valid_q)))
                begin
                    state_d = ST_STARTUP;
                    armed_d = 1'b0;
                    boot_d = 1'b0;
                end
            ST_CONFIG:
                if (cfg_wr)
                begin
                    cfg_cnt_d = cfg_cnt_q + 2'h1;
                    cfg_bad_d = cfg_bad_q || word_bad;
                    if (cfg_end && (cfg_bad_q || word_bad))
                    begin
                        state_d = ST_TORQ_OFF;
                        cfg_valid_d = 1'b0;
                        ev[`SCRS_EV_CFG_ERR] = 1'b1;
                        ev[`SCRS_EV_STOP] = 1'b1;
                    end
                    else if (cfg_end)
                    begin
                        state_d = ST_STARTUP;
                        cfg_valid_d = 1'b1;
                        armed_d = 1'b0;
                        // a later stop must need a reset, not auto-restart
                        boot_d = 1'b0;
                    end
                end
            ST_STARTUP:
                if (!both_high)
                begin
                    state_d = ST_TORQ_OFF;
                    ev[`SCRS_EV_STOP] = 1'b1;
                end
                else if (su_done && selftest_ok_in && pulse_disable_fb_in)
                begin
                    state_d = ST_RUN;
                    ev[`SCRS_EV_RUN] = 1'b1;
                end
                else if (su_done)
                begin
                    state_d = ST_TORQ_OFF;
                    ev[`SCRS_EV_TEST_ERR] = 1'b1;
                    ev[`SCRS_EV_STOP] = 1'b1;
                end
            ST_RUN:
                if (!both_high || fault_in)
                    state_d = ST_STOP_RAMP;
            ST_STOP_RAMP:
                if (ramp_done)
                begin
                    state_d = ST_TORQ_OFF;
                    ev[`SCRS_EV_STOP] = 1'b1;
                end
            default:
                state_d = ST_TORQ_OFF;
        endcase
    end

    // power stays on through the ramp so the drive can brake
    assign pwr_on = (state_q == ST_RUN) || (state_q == ST_STOP_RAMP);
    assign power_enable_out = pwr_on;
    assign torque_off_feedback_out = !pwr_on;
    assign ready_out = state_q == ST_RUN;
    assign controlled_stop_out = state_q == ST_STOP_RAMP;
    assign pulse_test_out = state_q == ST_STARTUP;
    assign configurable_outputs_out = (state_q == ST_RUN) ? outs_q : 4'h0;
    assign cfg_led_out = (state_q == ST_CONFIG) && blink_q;
    assign run_led_out = (state_q == ST_RUN) ||
                         ((state_q == ST_STARTUP) && blink_q);
    assign sto_led_out = (state_q == ST_TORQ_OFF) && blink_q;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            state_q <= ST_PWR;
            cfg_cnt_q <= 2'h0;
            cfg_bad_q <= 1'b0;
            cfg_valid_q <= 1'b0;
            boot_q <= 1'b1;
            armed_q <= 1'b0;
            blink_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cfg_cnt_q <= cfg_cnt_d;
            cfg_bad_q <= cfg_bad_d;
            cfg_valid_q <= cfg_valid_d;
            boot_q <= boot_d;
            armed_q <= armed_d;
            blink_q <= blink_d;
        end
    end

    // ------------------------------------------------------------
    // registers and interrupt
    // ------------------------------------------------------------
    always_comb
    begin
        wr_d = addr_ok && hwrite_in;
        waddr_d = {haddr_in[7:2], 2'h0};
        rdata_d = 32'h0;
        outs_d = outs_q;
        irq_en_d = irq_en_q;
        // a new event wins over a clear in the same cycle
        irq_st_d = irq_st_q | ev;
        if (addr_ok && !hwrite_in)
        begin
            if (waddr_d == `SCRS_CTRL_OFS)
                rdata_d = {20'h0, outs_q, 8'h0};
            else if (waddr_d == `SCRS_STATUS_OFS)
                rdata_d = {20'h0, outs_q, (state_q != ST_RUN), sync2_q,
                           armed_q, cfg_valid_q, state_q};
            else if (waddr_d == `SCRS_IRQ_STAT_OFS)
                rdata_d = {28'h0, irq_st_q};
            else if (waddr_d == `SCRS_IRQ_EN_OFS)
                rdata_d = {28'h0, irq_en_q};
            else
                rdata_d = 32'h0;
        end
        if (ctrl_wr)
            outs_d = hwdata_in[`SCRS_CTRL_OUT_LSB +: 4];
        else if (wr_q && (waddr_q == `SCRS_IRQ_EN_OFS))
            irq_en_d = hwdata_in[3:0];
        else if (wr_q && (waddr_q == `SCRS_IRQ_CLR_OFS))
            irq_st_d = (irq_st_q & ~hwdata_in[3:0]) | ev;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            wr_q <= 1'b0;
            waddr_q <= 8'h0;
            rdata_q <= 32'h0;
            outs_q <= `SCRS_OUTS_RST;
            irq_en_q <= `SCRS_IRQ_EN_RST;
            irq_st_q <= 4'h0;
        end
        else
        begin
            wr_q <= wr_d;
            waddr_q <= waddr_d;
            rdata_q <= rdata_d;
            outs_q <= outs_d;
            irq_en_q <= irq_en_d;
            irq_st_q <= irq_st_d;
        end
    end

    assign hrdata_out = rdata_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign irq_out = |(irq_st_q & irq_en_q);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    pwr_first_a: assert property ((state_q == ST_PWR) && supply_ok_in
        |=> state_q == ST_TORQ_OFF)
        else $error("power-on did not enter torque off");
    startup_low_a: assert property (state_q == ST_STARTUP
        |-> !ready_out && (configurable_outputs_out == 4'h0))
        else $error("outputs active during startup");
    test_fail_a: assert property ((state_q == ST_STARTUP) && su_done &&
        both_high && !selftest_ok_in |=> state_q == ST_TORQ_OFF)
        else $error("failed self test not handled");
    pass_run_a: assert property ((state_q == ST_STARTUP) && su_done &&
        both_high && selftest_ok_in && pulse_disable_fb_in
        |=> ready_out && power_enable_out && run_led_out)
        else $error("passed self test did not run");
    stop_entry_a: assert property ((state_q == ST_RUN) && !both_high
        |=> controlled_stop_out ##0 power_enable_out)
        else $error("low input did not start controlled stop");
    torque_fb_a: assert property (torque_off_feedback_out
        == ((state_q != ST_RUN) && (state_q != ST_STOP_RAMP)))
        else $error("torque-off feedback mismatch");
    cfg_bad_a: assert property (cfg_end && (cfg_bad_q || word_bad)
        |=> (state_q == ST_TORQ_OFF) && !power_enable_out)
        else $error("bad configuration accepted");
    cfg_blink_a: assert property ($rose(cfg_led_out)
        |-> state_q == ST_CONFIG)
        else $error("config indicator outside config");
    clr_gate_a: assert property ($rose(state_q == ST_STARTUP) &&
        ($past(state_q) == ST_TORQ_OFF) |-> $past(both_high))
        else $error("startup left stop with an input low");
    arm_min_a: assert property ($rose(armed_q)
        |-> $past(low_done))
        else $error("reset armed before minimum low time");
    run_steady_a: assert property ((state_q == ST_RUN)[*2]
        |-> run_led_out && $stable(run_led_out))
        else $error("run indicator not steady");

    run_c: cover property ((state_q == ST_STARTUP) ##1 (state_q == ST_RUN));
    cfg_err_c: cover property (cfg_end && (cfg_bad_q || word_bad));
    clr_c: cover property ((state_q == ST_TORQ_OFF) && clr_cmd && both_high);
    ramp_c: cover property ((state_q == ST_STOP_RAMP) && ramp_done);
endmodule : scrs_top

// ===== test/scrs_ctrl_model.sv
// model of the external safety controller driving the stop and reset lines
// assumes the bench calls pulse() right after a rising clk_in edge
`timescale 1ns/1ps
module scrs_ctrl_model #(
    parameter int MIN_LOW = 8
)
(
    input wire logic clk_in,
    output logic stop_request_input_out,
    output logic redundant_reset_input_out
);
    // --------------------------------------------------------------
    // line drive
    // --------------------------------------------------------------
    // both lines idle at the high level, so activation stays on
    initial
    begin
        stop_request_input_out = 1'b1;
        redundant_reset_input_out = 1'b1;
    end

    // sel 0 pulls the stop line, sel 1 the reset line, for cyc cycles;
    // callers give MIN_LOW or more unless a short pulse is wanted
    task automatic pulse(input int sel, input int cyc);
        if (sel == 0)
            stop_request_input_out <= 1'b0;
        else
            redundant_reset_input_out <= 1'b0;
        repeat (cyc) @(posedge clk_in);
        stop_request_input_out <= 1'b1;
        redundant_reset_input_out <= 1'b1;
    endtask : pulse
endmodule : scrs_ctrl_model

// ===== test/tb_top.sv
// self-checking bench of the startup and reset sequencer
// assumes shortened counts: min low 8, run-up 20, ramp 6, blink 4
`timescale 1ns/1ps
`include "scrs_params.svh"
module tb_top
    import scrs_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic supply_ok = 1'b0;
    logic selftest_ok = 1'b1;
    logic fault = 1'b0;
    logic [7:0] wiring = 8'h5C;
    logic pulse_fb = 1'b1;
    logic [2:0] hsize = 3'h2;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] d;
    logic [31:0] img [5][3];
    logic [3:0] outs;
    logic hready, hresp, rdy, pwr, cstop, tof, ptest, cfg_led, run_led;
    logic sto_led, irq, stop_l, rst_l;
    int err_count = 0;
    int check_count = 0;

    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end

    scrs_ctrl_model #(.MIN_LOW(8)) u_ctrl (
        .clk_in(clk_in),
        .stop_request_input_out(stop_l),
        .redundant_reset_input_out(rst_l)
    );

    scrs_top #(.MIN_LOW_CYC(8), .RUNUP_CYC(20), .RAMP_CYC(6),
        .BLINK_CYC(4)) dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .supply_ok_in(supply_ok),
        .stop_request_input_in(stop_l), .redundant_reset_input_in(rst_l),
        .wiring_in(wiring), .selftest_ok_in(selftest_ok),
        .pulse_disable_fb_in(pulse_fb), .fault_in(fault), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .ready_out(rdy), .configurable_outputs_out(outs),
        .power_enable_out(pwr), .controlled_stop_out(cstop),
        .torque_off_feedback_out(tof), .pulse_test_out(ptest),
        .cfg_led_out(cfg_led), .run_led_out(run_led), .sto_led_out(sto_led),
        .irq_out(irq)
    );

    // --------------------------------------------------------------
    // bus and check tasks
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk_in);
        while (hready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk_in);
        end
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [31:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] x;
        ahb(1'b1, a, wd, x);
    endtask : wr

    // polls the state field under a bounded number of reads
    task automatic wait_st(input logic [2:0] s, input int max);
        logic [31:0] x;
        int n;
        n = 0;
        ahb(1'b0, `SCRS_STATUS_OFS, 32'h0, x);
        while (x[2:0] !== s && n < max)
        begin
            n++;
            ahb(1'b0, `SCRS_STATUS_OFS, 32'h0, x);
        end
        chk("state", {29'h0, s}, {29'h0, x[2:0]});
    endtask : wait_st

    // an indicator sampled 12 cycles must toggle at least twice
    task automatic blink_chk(input int which, input string nm);
        logic [2:0] leds;
        logic prev;
        int t;
        t = 0;
        leds = {sto_led, run_led, cfg_led};
        prev = leds[which];
        repeat (12)
        begin
            @(posedge clk_in);
            leds = {sto_led, run_led, cfg_led};
            if (leds[which] !== prev)
                t++;
            prev = leds[which];
        end
        chk(nm, 32'h1, {31'h0, t >= 2});
    endtask : blink_chk

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial
    begin
        img[0] = '{`SCRS_ORDER_NUM ^ 32'h1, `SCRS_SERIAL_NUM, 32'h5C};
        img[1] = '{`SCRS_ORDER_NUM, `SCRS_SERIAL_NUM + 32'h1, 32'h5C};
        img[2] = '{`SCRS_ORDER_NUM, `SCRS_SERIAL_NUM, 32'h5D};
        img[3] = '{`SCRS_ORDER_NUM, `SCRS_SERIAL_NUM, 32'h0001_005C};
        img[4] = '{`SCRS_ORDER_NUM, `SCRS_SERIAL_NUM, 32'hA3};
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        chk("tof", 32'h1, {31'h0, tof});
        supply_ok <= 1'b1;
        wait_st(ST_TORQ_OFF, 10);
        for (int i = 0; i < 5; i++)
        begin
            // the good image matches a rewired card, not the first pattern
            if (i == 4)
                wiring <= 8'hA3;
            wr(`SCRS_CTRL_OFS, 32'h0000_0A01);
            if (i == 0)
            begin
                blink_chk(0, "cfg_led");
                chk("pwr", 32'h0, {31'h0, pwr});
            end
            for (int w = 0; w < 3; w++)
                wr(`SCRS_CFG_DATA_OFS, img[i][w]);
            if (i < 4)
            begin
                wait_st(ST_TORQ_OFF, 10);
                ahb(1'b0, `SCRS_IRQ_STAT_OFS, 32'h0, d);
                chk("cfg_err", 32'h1, {31'h0, d[2]});
                wr(`SCRS_IRQ_CLR_OFS, 32'hF);
            end
        end
        ahb(1'b0, `SCRS_STATUS_OFS, 32'h0, d);
        chk("startup", 32'h3, {29'h0, d[2:0]});
        chk("not_oper", 32'h1, {31'h0, d[7]});
        chk("ready", 32'h0, {31'h0, rdy});
        chk("outs", 32'h0, {28'h0, outs});
        chk("ptest", 32'h1, {31'h0, ptest});
        blink_chk(1, "run_led");
        wait_st(ST_RUN, 30);
        chk("ready", 32'h1, {31'h0, rdy});
        chk("pwr", 32'h1, {31'h0, pwr});
        chk("outs", 32'hA, {28'h0, outs});
        chk("tof", 32'h0, {31'h0, tof});
        repeat (10) @(posedge clk_in);
        chk("run_led", 32'h1, {31'h0, run_led});
        // interrupt: enable, mask, read back, clear, unmapped place
        wr(`SCRS_IRQ_EN_OFS, 32'h1);
        repeat (2) @(posedge clk_in);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`SCRS_IRQ_EN_OFS, 32'h0);
        repeat (2) @(posedge clk_in);
        chk("irq_mask", 32'h0, {31'h0, irq});
        wr(`SCRS_IRQ_EN_OFS, 32'h1);
        ahb(1'b0, `SCRS_IRQ_EN_OFS, 32'h0, d);
        chk("irq_en", 32'h1, d);
        wr(`SCRS_IRQ_CLR_OFS, 32'hF);
        repeat (2) @(posedge clk_in);
        chk("irq_clr", 32'h0, {31'h0, irq});
        ahb(1'b0, 32'h1C, 32'h0, d);
        chk("unmapped", 32'h0, d);
        wr(`SCRS_CTRL_OFS, 32'h0000_0A02);
        wait_st(ST_RUN, 0);
        for (int s = 0; s < 2; s++)
        begin
            fork
                u_ctrl.pulse(s, 30);
                begin
                    repeat (5) @(posedge clk_in);
                    chk("cstop", 32'h1, {31'h0, cstop});
                    chk("pwr", 32'h1, {31'h0, pwr});
                    repeat (8) @(posedge clk_in);
                    chk("tof", 32'h1, {31'h0, tof});
                    blink_chk(2, "sto_led");
                    // clear fault while the line is still low is refused
                    wr(`SCRS_CTRL_OFS, 32'h0000_0A02);
                    wait_st(ST_TORQ_OFF, 0);
                end
            join
            wait_st(ST_STARTUP, 5);
            wait_st(ST_RUN, 30);
        end
        // a pulse shorter than the minimum must not arm the restart
        u_ctrl.pulse(0, 5);
        wait_st(ST_TORQ_OFF, 20);
        repeat (10) @(posedge clk_in);
        wait_st(ST_TORQ_OFF, 0);
        wr(`SCRS_CTRL_OFS, 32'h0000_0A02);
        wait_st(ST_STARTUP, 3);
        wait_st(ST_RUN, 30);
        fault <= 1'b1;
        @(posedge clk_in);
        fault <= 1'b0;
        wait_st(ST_TORQ_OFF, 20);
        selftest_ok <= 1'b0;
        wr(`SCRS_CTRL_OFS, 32'h0000_0A02);
        wait_st(ST_STARTUP, 3);
        wait_st(ST_TORQ_OFF, 30);
        ahb(1'b0, `SCRS_IRQ_STAT_OFS, 32'h0, d);
        chk("test_err", 32'h1, {31'h0, d[3]});
        chk("ready", 32'h0, {31'h0, rdy});
        // a dead pulse-disable path must fail the startup test as well
        selftest_ok <= 1'b1;
        pulse_fb <= 1'b0;
        wr(`SCRS_CTRL_OFS, 32'h0000_0A02);
        wait_st(ST_STARTUP, 3);
        wait_st(ST_TORQ_OFF, 30);
        chk("ready", 32'h0, {31'h0, rdy});
        pulse_fb <= 1'b1;
        wr(`SCRS_CTRL_OFS, 32'h0000_0A02);
        wait_st(ST_RUN, 40);
        test_done();
    end

    // the whole sequence needs a few hundred cycles
    initial
    begin
        #100000;
        err_count++;
        $display("[ERR] watchdog exp done got timeout");
        test_done();
    end
endmodule : tb_top
